/* File: shared/uic_map.svh */
// Offsets, field positions, reset values and timing counts of the channel control block
`ifndef UIC_MAP_SVH
`define UIC_MAP_SVH
// Summary of operation
// [RULE1] 16-bit baud counter; divisor latches need format bit 7
// [RULE2] Receive interrupt follows trigger level in queue mode
// [RULE3] Data ready set on push, cleared when empty
// [RULE4] All mask bits zero means polled operation
// [RULE5] Mask bit 0 gates receive data interrupt
// [RULE6] Mask bit 1 gates transmit ready interrupt
// [RULE7] Mask bit 2 gates line status errors
// [RULE8] Mask bit 3 gates modem delta interrupt
// [RULE9] Source code priority: 6, c, 4, 2, 0, 1
// [RULE10] Source bit 0 low while anything pending
// [RULE11] Read shows only the highest pending source
// [RULE12] Timeout after four characters plus twelve bits
// [RULE13] Line and modem status reads clear their interrupts
// [RULE14] Source read or holding write clears transmit ready
// [RULE15] Source bits 7:6 mirror queue enable
// [RULE16] Control bit 0 must accompany other control bits
// [RULE17] Control bit 1 resets receive queue, self-clearing
// [RULE18] Control bit 2 resets transmit queue, self-clearing
// [RULE19] Control bit 3 selects DMA ready pin mode
// [RULE20] Control bits 7:6 select trigger 1/4/8/14
// [RULE21] Transmit empty and transmitter idle line status bits
// [RULE22] Line status bit 7 flags errors in queue
// [RULE23] Reserved mask and control bits ignored, read zero
// ==========================================================
// Register offsets
`define UIC_OFF_DATA   3'h0
`define UIC_OFF_MASK   3'h1
`define UIC_OFF_SRC    3'h2
`define UIC_OFF_FORMAT 3'h3
`define UIC_OFF_LINE   3'h5
`define UIC_OFF_MODEM  3'h6
// ==========================================================
// Field positions
`define UIC_LF_DLAB    7
`define UIC_QC_EN      0
`define UIC_QC_RXRST   1
`define UIC_QC_TXRST   2
`define UIC_QC_DMA     3
// ==========================================================
// Reset values
`define UIC_MASK_RST   4'h0
`define UIC_LF_RST     8'h00
`define UIC_DIV_RST    16'h0000
// ==========================================================
// Timing counts
`define UIC_OVERSAMPLE 16
`define UIC_TO_CHARS   4
`define UIC_TO_BITS    12
`define UIC_MIN_CHAR   4'h7
`endif

/* File: shared/uic_pkg.sv */
// Types shared by the channel control block
package uic_pkg;
  // Interrupt source codes, in falling priority
  typedef enum logic [3:0] {
    UIC_SRC_LINE = 4'h6,
    UIC_SRC_TMO  = 4'hc,
    UIC_SRC_RXD  = 4'h4,
    UIC_SRC_TXR  = 4'h2,
    UIC_SRC_MDM  = 4'h0,
    UIC_SRC_NONE = 4'h1
  } uic_src_t;
  // Receive trigger selection
  typedef enum logic [1:0] {
    UIC_TRIG_1  = 2'h0,
    UIC_TRIG_4  = 2'h1,
    UIC_TRIG_8  = 2'h2,
    UIC_TRIG_14 = 2'h3
  } uic_trig_t;
endpackage

/* File: core/uic_core.sv */
// Interrupt mask, prioritised source and queue control logic of one serial channel
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "uic_map.svh"
module uic_core #(
  parameter int DEPTH = 16 // Entries in each queue
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [2:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output      logic [7:0]        rdata,
  input  wire logic              rx_push,
  input  wire logic [7:0]        rx_char,
  input  wire logic [2:0]        rx_err,
  input  wire logic              tx_pop,
  input  wire logic              tx_shift_empty,
  input  wire logic [3:0]        msr_delta,
  input  wire logic [3:0]        msr_line,
  output      logic              irq,
  output      logic              rx_ready_pin_n,
  output      logic              tx_ready_pin_n,
  output      logic [7:0]        tx_data,
  output      logic              tx_valid,
  output      logic              baud_tick,
  output      logic              msr_read,
  output      logic [7:0]        line_format,
  output      logic              fifo_enabled,
  output      uic_pkg::uic_trig_t rx_trigger
);
  import uic_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // Trigger compare works on 8-bit levels, so the depth is bounded
  if (DEPTH < 16 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two from 16 to 128");
  end

  // ==========================================================
  // Register decode
  logic       dlab;       // Divisor latches selected
  logic       wr_thr;     // Host byte into transmit queue
  logic       wr_dll;     // Divisor low byte
  logic       wr_dlm;     // Divisor high byte
  logic       wr_mask;    // Interrupt mask write
  logic       wr_qc;      // Queue control write
  logic       qc_take;    // Control write carrying enable bit
  logic       rd_rhr;     // Receive holding read
  logic       rd_isr;     // Source read
  logic       rd_lsr;     // Line status read
  logic       rd_msr;     // Modem status read
  logic [3:0] interrupt_mask;
  logic       dma_mode;
  logic [15:0] divisor;

  assign dlab    = line_format[`UIC_LF_DLAB];
  assign wr_thr  = wr && addr == `UIC_OFF_DATA && !dlab;
  assign wr_dll  = wr && addr == `UIC_OFF_DATA && dlab; // [RULE1]
  assign wr_dlm  = wr && addr == `UIC_OFF_MASK && dlab; // [RULE1]
  assign wr_mask = wr && addr == `UIC_OFF_MASK && !dlab;
  assign wr_qc   = wr && addr == `UIC_OFF_SRC && !dlab;
  assign qc_take = wr_qc && wdata[`UIC_QC_EN]; // [RULE16]
  assign rd_rhr  = rd && addr == `UIC_OFF_DATA && !dlab;
  assign rd_isr  = rd && addr == `UIC_OFF_SRC && !dlab;
  assign rd_lsr  = rd && addr == `UIC_OFF_LINE;
  assign rd_msr  = rd && addr == `UIC_OFF_MODEM;

  // ==========================================================
  // Software registers
  // Mask keeps only its four low bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_mask <= `UIC_MASK_RST;
    end else if (wr_mask) begin
      interrupt_mask <= wdata[3:0]; // [RULE23]
    end
  end

  // Format register, also steering the divisor window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_format <= `UIC_LF_RST;
    end else if (wr && addr == `UIC_OFF_FORMAT) begin
      line_format <= wdata;
    end
  end

  // Queue control: a write with bit 0 low only disables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_enabled <= 1'b0;
      dma_mode     <= 1'b0;
      rx_trigger   <= UIC_TRIG_1;
    end else if (qc_take) begin
      fifo_enabled <= 1'b1;                          // [RULE16]
      dma_mode     <= wdata[`UIC_QC_DMA];            // [RULE19]
      rx_trigger   <= uic_trig_t'(wdata[7:6]);       // [RULE20]
    end else if (wr_qc) begin
      fifo_enabled <= 1'b0;                          // [RULE16]
    end
  end

  // Divisor latches, only reachable through the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divisor <= `UIC_DIV_RST;
    end else if (wr_dll) begin
      divisor[7:0] <= wdata; // [RULE1]
    end else if (wr_dlm) begin
      divisor[15:8] <= wdata; // [RULE1]
    end
  end

  // ==========================================================
  // Baud counter and bit timing
  logic [15:0] baud_counter; // Counts down to the next tick
  logic [3:0]  os_cnt;       // Ticks inside one bit time
  logic        bit_tick;

  // A zero divisor stops the counter; a divisor write restarts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_counter <= 16'h0000;
      baud_tick    <= 1'b0;
    end else if (wr_dll || wr_dlm || divisor == 16'h0000) begin
      baud_counter <= 16'h0000;
      baud_tick    <= 1'b0;
    end else if (baud_counter == 16'h0000) begin
      baud_counter <= divisor - 16'h0001; // [RULE1]
      baud_tick    <= 1'b1;
    end else begin
      baud_counter <= baud_counter - 16'h0001;
      baud_tick    <= 1'b0;
    end
  end

  assign bit_tick = baud_tick && os_cnt == 4'(`UIC_OVERSAMPLE - 1);

  // Oversample counter turning ticks into bit times
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      os_cnt <= 4'h0;
    end else if (baud_tick) begin
      os_cnt <= os_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Receive queue with error tags
  logic [10:0]   rx_mem [DEPTH]; // {break, framing, parity, char}
  logic [PW-1:0] rx_wr;
  logic [PW-1:0] rx_rd;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] err_cnt;        // Tagged entries held
  logic [CW-1:0] cap;            // One entry without queue mode
  logic          rx_full;
  logic          rx_do_push;
  logic          rx_do_pop;
  logic          rx_clear;
  logic [2:0]    head_err;
  logic [7:0]    trig_level;
  logic          rx_reach;
  logic [3:0]    lsr_err;        // {break, framing, parity, overrun}

  assign cap        = fifo_enabled ? CW'(DEPTH) : CW'(1);
  assign rx_full    = rx_cnt >= cap;
  assign rx_clear   = qc_take && wdata[`UIC_QC_RXRST]; // [RULE17]
  assign rx_do_push = rx_push && !rx_full && !rx_clear;
  assign rx_do_pop  = rd_rhr && rx_cnt != '0 && !rx_clear;
  assign head_err   = rx_mem[rx_rd][10:8];

  // Trigger level; without queue mode one character suffices
  always_comb begin
    trig_level = 8'h01;
    if (fifo_enabled) begin
      unique case (rx_trigger)
        UIC_TRIG_1:  trig_level = 8'h01; // [RULE20]
        UIC_TRIG_4:  trig_level = 8'h04;
        UIC_TRIG_8:  trig_level = 8'h08;
        UIC_TRIG_14: trig_level = 8'h0e;
      endcase
    end
  end
  assign rx_reach = 8'(rx_cnt) >= trig_level; // [RULE2]

  // Storage has no reset; the count says what is valid
  always_ff @(posedge clk) begin
    if (rx_do_push) begin
      rx_mem[rx_wr] <= {rx_err, rx_char};
    end
  end

  // Pointers and level; the reset leaves the shifter alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_wr   <= '0;
      rx_rd   <= '0;
      rx_cnt  <= '0;
      err_cnt <= '0;
    end else if (rx_clear) begin
      rx_wr   <= '0; // [RULE17]
      rx_rd   <= '0;
      rx_cnt  <= '0;
      err_cnt <= '0;
    end else begin
      if (rx_do_push) rx_wr <= rx_wr + PW'(1);
      if (rx_do_pop) rx_rd <= rx_rd + PW'(1);
      rx_cnt  <= rx_cnt + CW'(rx_do_push) - CW'(rx_do_pop);
      err_cnt <= err_cnt + CW'(rx_do_push && rx_err != 3'h0)
                 - CW'(rx_do_pop && head_err != 3'h0); // [RULE22]
    end
  end

  // Overrun flags at once; tags flag as their character leaves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lsr_err <= 4'h0;
    end else begin
      lsr_err <= (rd_lsr ? 4'h0 : lsr_err)                  // [RULE13]
                 | {rx_do_pop ? head_err : 3'h0, rx_push && rx_full}; // [RULE7]
    end
  end

  // ==========================================================
  // Receive timeout
  logic [3:0] char_bits; // Start, data, parity and stop bits
  logic [6:0] to_limit;
  logic [6:0] to_bits;
  logic       to_hit;
  logic       to_flag;

  assign char_bits = `UIC_MIN_CHAR + {2'h0, line_format[1:0]}
                     + {3'h0, line_format[3]} + {3'h0, line_format[2]};
  assign to_limit  = 7'({3'h0, char_bits} * 7'(`UIC_TO_CHARS)) + 7'(`UIC_TO_BITS); // [RULE12]
  // The read restarts the timer, so it cannot count as a fresh hit
  assign to_hit    = fifo_enabled && rx_cnt != '0 && to_bits == to_limit && !rd_rhr;

  // Bit times since the last push or read while data waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_bits <= 7'h00;
    end else if (!fifo_enabled || rx_cnt == '0 || rx_push || rd_rhr) begin
      to_bits <= 7'h00;
    end else if (bit_tick && to_bits != to_limit) begin
      to_bits <= to_bits + 7'h01; // [RULE12]
    end
  end

  // Sticky timeout, cleared by a holding read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_flag <= 1'b0;
    end else begin
      to_flag <= (to_flag && !rd_rhr && !rx_clear) || to_hit; // [RULE12]
    end
  end

  // ==========================================================
  // Transmit queue
  logic [7:0]    tx_mem [DEPTH];
  logic [PW-1:0] tx_wr;
  logic [PW-1:0] tx_rd;
  logic [CW-1:0] tx_cnt;
  logic [PW-1:0] next_tx_rd;
  logic [CW-1:0] next_tx_cnt;
  logic          tx_full;
  logic          tx_do_push;
  logic          tx_do_pop;
  logic          tx_clear;
  logic          tx_went_empty;
  logic          tx_flag;
  logic          mask1_d;

  assign tx_full     = tx_cnt >= cap;
  assign tx_clear    = qc_take && wdata[`UIC_QC_TXRST]; // [RULE18]
  assign tx_do_push  = wr_thr && !tx_full && !tx_clear;
  assign tx_do_pop   = tx_pop && tx_cnt != '0 && !tx_clear;
  assign next_tx_rd  = tx_clear ? '0 : tx_rd + PW'(tx_do_pop);
  assign next_tx_cnt = tx_clear ? '0 : tx_cnt + CW'(tx_do_push) - CW'(tx_do_pop);

  always_ff @(posedge clk) begin
    if (tx_do_push) begin
      tx_mem[tx_wr] <= wdata;
    end
  end

  // Pointers and level; the shifter keeps its byte on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_wr  <= '0;
      tx_rd  <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wr  <= tx_clear ? '0 : tx_wr + PW'(tx_do_push); // [RULE18]
      tx_rd  <= next_tx_rd;
      tx_cnt <= next_tx_cnt;
    end
  end

  // Head byte for the shifter, bypassing a write into empty
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      tx_data  <= (tx_do_push && tx_wr == next_tx_rd) ? wdata : tx_mem[next_tx_rd];
      tx_valid <= next_tx_cnt != '0;
    end
  end

  assign tx_went_empty = (tx_cnt != '0 && next_tx_cnt == '0)
                         || (interrupt_mask[1] && !mask1_d && tx_cnt == '0);

  // ==========================================================
  // Source priority
  logic     p_ls;
  logic     p_to;
  logic     p_rx;
  logic     p_tx;
  logic     p_ms;
  uic_src_t src;

  assign p_ls = interrupt_mask[2] && lsr_err != 4'h0;  // [RULE7]
  assign p_to = interrupt_mask[0] && to_flag;          // [RULE12]
  assign p_rx = interrupt_mask[0] && rx_reach;         // [RULE5]
  assign p_tx = interrupt_mask[1] && tx_flag;          // [RULE6]
  assign p_ms = interrupt_mask[3] && msr_delta != 4'h0; // [RULE8]

  // Only the top source is shown; the rest wait behind it
  always_comb begin
    src = UIC_SRC_NONE;
    if (p_ls) src = UIC_SRC_LINE; // [RULE9] [RULE11]
    else if (p_to) src = UIC_SRC_TMO;
    else if (p_rx) src = UIC_SRC_RXD;
    else if (p_tx) src = UIC_SRC_TXR;
    else if (p_ms) src = UIC_SRC_MDM;
  end

  // Transmit ready is an event; a new empty beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_flag <= 1'b0;
      mask1_d <= 1'b0;
    end else begin
      mask1_d <= interrupt_mask[1];
      tx_flag <= (tx_flag && !wr_thr && !(rd_isr && src == UIC_SRC_TXR))
                 || tx_went_empty; // [RULE14]
    end
  end

  // Interrupt line; silent when every mask bit is zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= src != UIC_SRC_NONE; // [RULE4] [RULE10]
    end
  end

  // ==========================================================
  // Ready pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ready_pin_n <= 1'b1;
      tx_ready_pin_n <= 1'b0;
    end else begin
      if (!dma_mode || rx_cnt == '0) begin
        rx_ready_pin_n <= rx_cnt == '0; // [RULE19]
      end else if (rx_reach || to_flag) begin
        rx_ready_pin_n <= 1'b0;
      end
      tx_ready_pin_n <= dma_mode ? tx_full : tx_cnt != '0; // [RULE19]
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  logic [7:0] next_rdata;
  logic       tx_empty;

  assign tx_empty = tx_cnt == '0;

  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      `UIC_OFF_DATA:   next_rdata = dlab ? divisor[7:0] : rx_mem[rx_rd][7:0];
      `UIC_OFF_MASK:   next_rdata = dlab ? divisor[15:8] : {4'h0, interrupt_mask}; // [RULE23]
      `UIC_OFF_SRC:    next_rdata = dlab ? 8'h00 : {{2{fifo_enabled}}, 2'h0, src}; // [RULE15]
      `UIC_OFF_FORMAT: next_rdata = line_format;
      `UIC_OFF_LINE:   next_rdata = {err_cnt != '0, tx_empty && tx_shift_empty, // [RULE21] [RULE22]
                                     tx_empty, lsr_err, rx_cnt != '0};          // [RULE3]
      `UIC_OFF_MODEM:  next_rdata = {msr_line, msr_delta};
      default:         next_rdata = 8'h00;
    endcase
    if (!dlab && addr == `UIC_OFF_DATA && rx_cnt == '0) next_rdata = 8'h00;
  end

  // Registered answer and modem read pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata    <= 8'h00;
      msr_read <= 1'b0;
    end else begin
      rdata    <= rd ? next_rdata : 8'h00;
      msr_read <= rd_msr; // [RULE13]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic irq_any; // Any enabled source pending
  assign irq_any = p_ls || p_to || p_rx || p_tx || p_ms;
  src_idle_a: assert property (rd_isr |=> rdata[0] == !$past(irq_any)) else $error("idle bit wrong"); // [RULE10]
  line_first_a: assert property (rd_isr && p_ls |=> rdata[3:0] == 4'h6) else $error("line not first"); // [RULE9]
  tmo_second_a: assert property (rd_isr && !p_ls && p_to |=> rdata[3:0] == 4'hc)
    else $error("timeout code wrong"); // [RULE11]
  src_fifo_a: assert property (rd_isr |=> rdata[7:6] == {2{$past(fifo_enabled)}}) else $error("bits 7:6"); // [RULE15]
  rx_reset_a: assert property (qc_take && wdata[1] |=> rx_cnt == '0 ##1 rx_cnt <= 1)
    else $error("rx reset failed"); // [RULE17]
  tx_reset_a: assert property (qc_take && wdata[2] |=> tx_cnt == '0) else $error("tx reset failed"); // [RULE18]
  qc_ignore_a: assert property (wr_qc && !wdata[0] |=> !fifo_enabled && $stable(dma_mode) && $stable(rx_trigger))
    else $error("control bits taken"); // [RULE16]
  div_lock_a: assert property (wr && !dlab && addr <= 3'h1 |=> $stable(divisor))
    else $error("divisor written"); // [RULE1]
  polled_a: assert property (interrupt_mask == 4'h0 |=> !irq) else $error("irq in polled mode"); // [RULE4]
  lsr_clr_a: assert property (rd_lsr && !rx_do_pop && !(rx_push && rx_full) |=> lsr_err == 4'h0)
    else $error("line clear failed"); // [RULE13]
  thr_clr_a: assert property (wr_thr && !tx_went_empty |=> !tx_flag) else $error("tx ready kept"); // [RULE14]
  tmo_set_a: assert property (to_hit |=> to_flag [*2] or (to_flag ##1 $fell(to_flag)))
    else $error("timeout lost"); // [RULE12]

  rx_trig_c: cover property (p_rx ##1 irq);
  tmo_c:     cover property ($rose(to_flag));
  ovr_c:     cover property (rx_push && rx_full);
  txr_c:     cover property (tx_flag ##1 rd_isr);
endmodule

/* File: verification/uic_line_model.sv */
// Far-side model: receive shifter that offers characters and transmit shifter that drains the queue
`timescale 1ns/1ps
module uic_line_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output      logic       tx_pop,
  output      logic       tx_shift_empty,
  output      logic [7:0] last_tx,
  output      logic       rx_push,
  output      logic [7:0] rx_char,
  output      logic [2:0] rx_err
);
  logic [3:0] busy_cnt; // Cycles left on the character in the shifter
  // ==========================================================
  // Receive shifter
  initial begin
    rx_push = 1'b0;
    rx_char = 8'h00;
    rx_err  = 3'h0;
  end
  // Offer one character; lines go to the inverse afterwards so stale data never looks valid
  task automatic send(input logic [7:0] c, input logic [2:0] e);
    rx_char <= c;
    rx_err  <= e;
    rx_push <= 1'b1;
    @(posedge clk);
    rx_push <= 1'b0;
    rx_char <= ~c;
    rx_err  <= ~e;
    @(posedge clk);
  endtask
  // ==========================================================
  // Transmit shifter: one pop, then a busy spell, so a stale valid never pops twice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pop   <= 1'b0;
      busy_cnt <= 4'h0;
      last_tx  <= 8'h00;
    end else begin
      tx_pop <= 1'b0;
      if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end else if (run && tx_valid) begin
        tx_pop   <= 1'b1;
        last_tx  <= tx_data;
        busy_cnt <= 4'h8;
      end
    end
  end
  assign tx_shift_empty = (busy_cnt == 4'h0);
endmodule

/* File: verification/tb_uart_interrupt_fifo_control.sv */
// Self-checking bench for the channel interrupt and queue control block
`timescale 1ns/1ps
module tb_uart_interrupt_fifo_control;
  import uic_pkg::*;
  // ==========================================================
  // Signals
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       run = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] msr_delta = 4'h0;
  logic [3:0] msr_line = 4'h0;
  logic [7:0] rdata, tx_data, last_tx, rx_char, line_format;
  logic       irq, rx_ready_pin_n, tx_ready_pin_n, tx_valid, baud_tick, msr_read, fifo_enabled;
  logic       rx_push, tx_pop, tx_shift_empty;
  logic [2:0] rx_err;
  uic_trig_t  rx_trigger;
  int         fails = 0;
  int         samples_checked = 0;
  always #4 clk = ~clk;
  uic_core #(.DEPTH(16)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_push(rx_push), .rx_char(rx_char), .rx_err(rx_err), .tx_pop(tx_pop),
    .tx_shift_empty(tx_shift_empty), .msr_delta(msr_delta), .msr_line(msr_line), .irq(irq),
    .rx_ready_pin_n(rx_ready_pin_n), .tx_ready_pin_n(tx_ready_pin_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .baud_tick(baud_tick), .msr_read(msr_read), .line_format(line_format),
    .fifo_enabled(fifo_enabled), .rx_trigger(rx_trigger));
  uic_line_model far (.clk(clk), .rst(rst), .run(run), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_pop(tx_pop), .tx_shift_empty(tx_shift_empty), .last_tx(last_tx), .rx_push(rx_push),
    .rx_char(rx_char), .rx_err(rx_err));
  // Outside logic drops its modem deltas when the status read is reported
  always @(posedge clk) begin
    if (msr_read === 1'b1) begin
      msr_delta <= 4'h0;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe, so look mid-cycle there
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, rdata, exp);
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(3'h1, 8'h00, "mask reset");
    rd_chk(3'h2, 8'h01, "source reset");
    wr_reg(3'h1, 8'hff);
    rd_chk(3'h1, 8'h0f, "mask reserved");
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h2, 8'h01);
    rd_chk(3'h2, 8'hc1, "polled source");
    wr_reg(3'h2, 8'hc0);
    chk("queue off", fifo_enabled, 8'h00);
    chk("trigger kept", rx_trigger, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_trigger;
    int lv [4] = '{1, 4, 8, 14};
    wr_reg(3'h1, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr_reg(3'h2, {t[1:0], 6'h03});
      chk("trigger", rx_trigger, t);
      for (int i = 1; i < lv[t]; i++) far.send(8'h30 + i[7:0], 3'h0);
      cyc(3);
      chk("below level", irq, 8'h00);
      far.send(8'h2f, 3'h0);
      cyc(3);
      chk("at level", irq, 8'h01);
      chk("normal rx pin", rx_ready_pin_n, 8'h00);
      rd_chk(3'h2, 8'hc4, "rx source");
      rd_chk(3'h0, (lv[t] == 1) ? 8'h2f : 8'h31, "head char");
      cyc(3);
      chk("dropped below", irq, 8'h00);
    end
    wr_reg(3'h2, 8'h4b);
    far.send(8'h55, 3'h0);
    cyc(3);
    chk("dma rx pin", rx_ready_pin_n, 8'h01);
    chk("dma tx pin", tx_ready_pin_n, 8'h00);
    for (int i = 0; i < 3; i++) far.send(8'h56, 3'h0);
    cyc(2);
    chk("dma rx level", rx_ready_pin_n, 8'h00);
    wr_reg(3'h2, 8'h03);
    rd_chk(3'h5, 8'h60, "flushed status");
    $display("trigger test done");
  endtask
  task automatic t_transmit;
    wr_reg(3'h1, 8'h02);
    cyc(3);
    chk("tx ready irq", irq, 8'h01);
    rd_chk(3'h2, 8'hc2, "tx source");
    rd_chk(3'h2, 8'hc1, "cleared by read");
    wr_reg(3'h0, 8'h5a);
    chk("tx valid", tx_valid, 8'h01);
    chk("tx head", tx_data, 8'h5a);
    rd_chk(3'h5, 8'h00, "tx busy status");
    chk("normal tx pin", tx_ready_pin_n, 8'h01);
    run <= 1'b1;
    cyc(15);
    chk("sent byte", last_tx, 8'h5a);
    rd_chk(3'h5, 8'h60, "tx idle status");
    chk("empty irq", irq, 8'h01);
    run <= 1'b0;
    wr_reg(3'h0, 8'h11);
    cyc(3);
    chk("cleared by write", irq, 8'h00);
    wr_reg(3'h2, 8'h05);
    rd_chk(3'h2, 8'hc2, "tx reset empties");
    rd_chk(3'h5, 8'h60, "tx flushed");
    $display("transmit test done");
  endtask
  task automatic t_line;
    wr_reg(3'h1, 8'h04);
    far.send(8'h41, 3'h1);
    cyc(3);
    chk("parity waits", irq, 8'h00);
    rd_chk(3'h5, 8'he1, "error in queue");
    rd_chk(3'h0, 8'h41, "error char");
    cyc(3);
    chk("parity irq", irq, 8'h01);
    rd_chk(3'h2, 8'hc6, "line source");
    rd_chk(3'h5, 8'h64, "parity status");
    cyc(3);
    chk("line cleared", irq, 8'h00);
    wr_reg(3'h2, 8'h00);
    far.send(8'h61, 3'h0);
    far.send(8'h62, 3'h0);
    cyc(3);
    rd_chk(3'h2, 8'h06, "overrun source");
    rd_chk(3'h5, 8'h63, "overrun status");
    rd_chk(3'h0, 8'h61, "kept char");
    $display("line status test done");
  endtask
  task automatic t_modem;
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h1, 8'h0a);
    msr_line  <= 4'ha;
    msr_delta <= 4'h2;
    cyc(3);
    rd_chk(3'h2, 8'hc2, "tx over modem");
    rd_chk(3'h2, 8'hc0, "modem source");
    rd_chk(3'h6, 8'ha2, "modem status");
    cyc(3);
    chk("modem cleared", irq, 8'h00);
    rd_chk(3'h2, 8'hc1, "none pending");
    $display("modem test done");
  endtask
  task automatic t_divisor;
    int n;
    wr_reg(3'h3, 8'h80);
    chk("format", line_format, 8'h80);
    wr_reg(3'h0, 8'h03);
    wr_reg(3'h1, 8'h00);
    rd_chk(3'h0, 8'h03, "divisor low");
    rd_chk(3'h2, 8'h00, "window source");
    // Tick is looked at mid-cycle, where it has settled
    for (n = 0; n < 20 && baud_tick !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 20 && baud_tick !== 1'b1; n++) @(negedge clk);
    chk("tick period", n, 8'h03);
    @(posedge clk);
    wr_reg(3'h3, 8'h00);
    rd_chk(3'h1, 8'h0a, "mask back");
    wr_reg(3'h1, 8'h01);
    wr_reg(3'h2, 8'h47);
    far.send(8'h77, 3'h0);
    for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
    rd_chk(3'h2, 8'hcc, "timeout source");
    rd_chk(3'h0, 8'h77, "timeout char");
    cyc(3);
    chk("timeout cleared", irq, 8'h00);
    $display("divisor test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_trigger;
    t_transmit;
    t_line;
    t_modem;
    t_divisor;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
